// *** shared/bpcm_pkg.sv ***
package bpcm_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h29;
    localparam logic [7:0] IDX_A_EXT = 8'h2A;
    localparam logic [7:0] IDX_A_HIGH = 8'h2B;
    localparam logic [7:0] IDX_A_LOW = 8'h2C;
    localparam logic [7:0] IDX_B_EXT = 8'h2D;
    localparam logic [7:0] IDX_B_HIGH = 8'h2E;
    localparam logic [7:0] IDX_B_LOW = 8'h2F;
    localparam logic [7:0] IDX_MODE = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    // control register fields
    localparam int CTRL_A_MASK_HI = 7;
    localparam int CTRL_A_MASK_LO = 6;
    localparam int CTRL_B_MASK_HI = 5;
    localparam int CTRL_B_MASK_LO = 4;
    localparam int CTRL_A_DIR_EN = 3;
    localparam int CTRL_A_DIR_VAL = 2;
    localparam int CTRL_B_DIR_EN = 1;
    localparam int CTRL_B_DIR_VAL = 0;
    // mode register fields
    localparam int MODE_FULL = 0;
    localparam int MODE_COMPAT = 1;
    localparam int MODE_TRACE = 2;
    // status register fields
    localparam int STAT_MATCH_A = 0;
    localparam int STAT_MATCH_B = 1;
    // widths and reset values
    localparam int EXT_W = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

// *** shared/bpcm_cmp_if.sv ***
`timescale 1ns/1ns
interface bpcm_cmp_if;
    // comparator setting
    logic [5:0] ext;
    logic [7:0] high;
    logic [7:0] low;
    logic mask_hi;
    logic mask_lo;
    logic data_mode;
    logic dir_en;
    logic dir_val;
    logic active;
    // observed cpu bus
    logic [15:0] addr;
    logic [15:0] data;
    logic [5:0] page;
    logic page_sel;
    logic read;
    logic valid;
    // result
    logic match;

    modport ctrl (
        output ext, high, low, mask_hi, mask_lo, data_mode, dir_en, dir_val, active,
        output addr, data, page, page_sel, read, valid,
        input match
    );
    modport cmp (
        input ext, high, low, mask_hi, mask_lo, data_mode, dir_en, dir_val, active,
        input addr, data, page, page_sel, read, valid,
        output match
    );
endinterface // bpcm_cmp_if

// *** hdl/bpcm_comparator.sv ***
`timescale 1ns/1ns
module bpcm_comparator (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // setting, bus and result
    bpcm_cmp_if.cmp c
);
    logic hi_use;
    logic lo_use;
    logic hi_eq;
    logic lo_eq;
    logic ext_ok;
    logic page_miss;
    logic dir_ok;
    logic match_reg;
    logic match_next;

    always_comb
    begin
        if (c.data_mode)
        begin
            // data byte masks, no extended compare
            hi_use = !c.mask_hi;
            lo_use = !c.mask_lo;
            hi_eq = (c.high == c.data[15:8]);
            lo_eq = (c.low == c.data[7:0]);
            ext_ok = 1'b1;
            page_miss = 1'b0;
        end
        else
        begin
            // mask code 1:0 keeps the high byte
            hi_use = !(c.mask_hi && c.mask_lo);
            // 0:1 drops low byte, 1:1 both
            lo_use = !c.mask_lo;
            lo_eq = (c.low == c.addr[7:0]);
            if (c.page_sel)
            begin
                hi_eq = (c.high[5:0] == c.addr[13:8]);
                ext_ok = (c.ext == c.page);
            end
            else
            begin
                hi_eq = (c.high == c.addr[15:8]);
                ext_ok = 1'b1;
            end
            // page-only compare needs a program page
            page_miss = c.mask_hi && c.mask_lo && !c.page_sel;
        end
        dir_ok = !c.dir_en || (c.read == c.dir_val);
    end

    // all unmasked parts on one cycle
    assign match_next = c.active && c.valid && ext_ok && !page_miss && dir_ok &&
        (!hi_use || hi_eq) && (!lo_use || lo_eq);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_reg <= 1'b0;
        else
            match_reg <= match_next;
    end

    assign c.match = match_reg;
endmodule // bpcm_comparator

// *** hdl/bpcm_top.sv ***
// Our own choice: the APB register port.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Operation
// - trace mode forces first masks to zero
// - trace mode uses second masks only full
// - page selected gives 20-bit address compare
// - no page gives 16-bit address compare
// - mask code 1:0 compares all lines
// - first mask 0:1 256 byte, 1:1 16K
// - extended compare only with program page
// - dual mode second comparator same masks
// - full mode second masks pick data bytes
// - comparator A direction enable qualifies match
// - comparator A value: 0 write, 1 read
// - comparator B direction enable and value
// - full mode ignores comparator B direction
// - compat mode compares logical page bits
// - full mode: A address, B data
module bpcm_top #(
    parameter int ADDR_W = 12
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // observed cpu bus
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_data,
    input wire logic [5:0] cpu_page,
    input wire logic cpu_page_sel,
    input wire logic cpu_read,
    input wire logic cpu_valid,
    // comparator results
    output logic match_a,
    output logic match_b
);
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_check
        $error("bpcm_top: ADDR_W must lie between 8 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] breakpoint_mask_rw_control_reg;
    logic [7:0] mode_reg;
    logic [7:0] comp_a_extended_reg;
    logic [7:0] comp_a_high_byte_reg;
    logic [7:0] comp_a_low_byte_reg;
    logic [7:0] comp_b_extended_reg;
    logic [7:0] comp_b_high_byte_reg;
    logic [7:0] comp_b_low_byte_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    logic [ADDR_W-3:0] full_index;
    logic [7:0] reg_index;
    logic addr_mapped;
    logic setup_phase;
    logic access_wr;
    logic compat_breakpoint_mode;
    logic trace_debug_mode;
    logic full_mode;

    bpcm_cmp_if a_if ();
    bpcm_cmp_if b_if ();

    function automatic logic is_mapped(input logic [7:0] idx);
        return (idx >= bpcm_pkg::IDX_CTRL) && (idx <= bpcm_pkg::IDX_STATUS);
    endfunction

    function automatic logic [7:0] reg_value(input logic [7:0] idx);
        logic [7:0] v;
        v = bpcm_pkg::CMP_RESET;
        unique case (idx)
            bpcm_pkg::IDX_CTRL: v = breakpoint_mask_rw_control_reg;
            bpcm_pkg::IDX_A_EXT: v = comp_a_extended_reg;
            bpcm_pkg::IDX_A_HIGH: v = comp_a_high_byte_reg;
            bpcm_pkg::IDX_A_LOW: v = comp_a_low_byte_reg;
            bpcm_pkg::IDX_B_EXT: v = comp_b_extended_reg;
            bpcm_pkg::IDX_B_HIGH: v = comp_b_high_byte_reg;
            bpcm_pkg::IDX_B_LOW: v = comp_b_low_byte_reg;
            bpcm_pkg::IDX_MODE: v = mode_reg;
            bpcm_pkg::IDX_STATUS:
            begin
                v[bpcm_pkg::STAT_MATCH_A] = a_if.match;
                v[bpcm_pkg::STAT_MATCH_B] = b_if.match;
            end
            default: v = bpcm_pkg::CMP_RESET;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: pready rises in the first access cycle
    assign full_index = paddr[ADDR_W-1:2];
    // eight index bits select the register; higher index bits must be clear or the access gets pslverr
    assign reg_index = 8'(full_index);
    assign addr_mapped = ((full_index >> 8) == '0) && is_mapped(reg_index);
    assign setup_phase = psel && !penable && !pready_reg;
    assign access_wr = psel && penable && pready_reg && pwrite && addr_mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready_reg <= 1'b0;
        else
            pready_reg <= setup_phase;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_reg <= 1'b0;
        else if (setup_phase)
            pslverr_reg <= !addr_mapped;
        else
            pslverr_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= bpcm_pkg::DATA_ZERO;
        else if (setup_phase && !pwrite)
            prdata_reg <= {24'h00_0000, addr_mapped ? reg_value(reg_index) : bpcm_pkg::CMP_RESET};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            breakpoint_mask_rw_control_reg <= bpcm_pkg::CTRL_RESET;
        else if (access_wr && reg_index == bpcm_pkg::IDX_CTRL)
            breakpoint_mask_rw_control_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= bpcm_pkg::MODE_RESET;
        else if (access_wr && reg_index == bpcm_pkg::IDX_MODE)
            mode_reg <= {5'h00, pwdata[2:0]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            comp_a_extended_reg <= bpcm_pkg::CMP_RESET;
            comp_a_high_byte_reg <= bpcm_pkg::CMP_RESET;
            comp_a_low_byte_reg <= bpcm_pkg::CMP_RESET;
        end
        else if (access_wr)
        begin
            if (reg_index == bpcm_pkg::IDX_A_EXT)
                comp_a_extended_reg <= {2'h0, pwdata[5:0]};
            if (reg_index == bpcm_pkg::IDX_A_HIGH)
                comp_a_high_byte_reg <= pwdata[7:0];
            if (reg_index == bpcm_pkg::IDX_A_LOW)
                comp_a_low_byte_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            comp_b_extended_reg <= bpcm_pkg::CMP_RESET;
            comp_b_high_byte_reg <= bpcm_pkg::CMP_RESET;
            comp_b_low_byte_reg <= bpcm_pkg::CMP_RESET;
        end
        else if (access_wr)
        begin
            if (reg_index == bpcm_pkg::IDX_B_EXT)
                comp_b_extended_reg <= {2'h0, pwdata[5:0]};
            if (reg_index == bpcm_pkg::IDX_B_HIGH)
                comp_b_high_byte_reg <= pwdata[7:0];
            if (reg_index == bpcm_pkg::IDX_B_LOW)
                comp_b_low_byte_reg <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode: compatibility overrides trace; neither leaves both comparators off
    assign compat_breakpoint_mode = mode_reg[bpcm_pkg::MODE_COMPAT];
    assign trace_debug_mode = mode_reg[bpcm_pkg::MODE_TRACE] && !compat_breakpoint_mode;
    assign full_mode = mode_reg[bpcm_pkg::MODE_FULL];

    // page bits are taken as the core presents them, logical in compat mode
    assign a_if.addr = cpu_addr;
    assign a_if.data = cpu_data;
    assign a_if.page = cpu_page;
    assign a_if.page_sel = cpu_page_sel;
    assign a_if.read = cpu_read;
    assign a_if.valid = cpu_valid;
    assign a_if.active = compat_breakpoint_mode || trace_debug_mode;
    assign a_if.ext = comp_a_extended_reg[5:0];
    assign a_if.high = comp_a_high_byte_reg;
    assign a_if.low = comp_a_low_byte_reg;
    // comparator A always compares the address
    assign a_if.data_mode = 1'b0;
    // first masks forced clear in trace mode
    assign a_if.mask_hi = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_A_MASK_HI] && !trace_debug_mode;
    assign a_if.mask_lo = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_A_MASK_LO] && !trace_debug_mode;
    // direction value selects write or read
    assign a_if.dir_en = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_A_DIR_EN];
    assign a_if.dir_val = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_A_DIR_VAL];

    assign b_if.addr = cpu_addr;
    assign b_if.data = cpu_data;
    assign b_if.page = cpu_page;
    assign b_if.page_sel = cpu_page_sel;
    assign b_if.read = cpu_read;
    assign b_if.valid = cpu_valid;
    assign b_if.active = compat_breakpoint_mode || trace_debug_mode;
    assign b_if.ext = comp_b_extended_reg[5:0];
    assign b_if.high = comp_b_high_byte_reg;
    assign b_if.low = comp_b_low_byte_reg;
    // comparator B watches data in full mode
    assign b_if.data_mode = full_mode;
    // trace mode uses second masks in full only; dual uses address codes
    assign b_if.mask_hi = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_B_MASK_HI] &&
        !(trace_debug_mode && !full_mode);
    assign b_if.mask_lo = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_B_MASK_LO] &&
        !(trace_debug_mode && !full_mode);
    // full mode drops comparator B direction
    assign b_if.dir_en = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_B_DIR_EN] && !full_mode;
    assign b_if.dir_val = breakpoint_mask_rw_control_reg[bpcm_pkg::CTRL_B_DIR_VAL];

    bpcm_comparator u_cmp_a (
        .pclk(pclk),
        .presetn(presetn),
        .c(a_if.cmp)
    );

    bpcm_comparator u_cmp_b (
        .pclk(pclk),
        .presetn(presetn),
        .c(b_if.cmp)
    );

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;
    assign match_a = a_if.match;
    assign match_b = b_if.match;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_apb_ready_first: assert property (setup_phase |=> pready && !$past(pready))
        else $error("pready did not rise after setup");

    a_ctrl_write_takes: assert property (access_wr && reg_index == bpcm_pkg::IDX_CTRL |=>
        breakpoint_mask_rw_control_reg == $past(pwdata[7:0]))
        else $error("control register write lost");

    a_trace_first_mask: assert property (trace_debug_mode && cpu_valid &&
        cpu_addr[7:0] != comp_a_low_byte_reg |=> !match_a)
        else $error("first mask honoured in trace mode");

    a_mask10_full_cmp: assert property (compat_breakpoint_mode && !cpu_page_sel &&
        breakpoint_mask_rw_control_reg[7:6] == 2'b10 && cpu_addr[15:8] != comp_a_high_byte_reg |=> !match_a)
        else $error("mask code 1:0 skipped high byte");

    a_page_only_need: assert property (compat_breakpoint_mode && !cpu_page_sel &&
        breakpoint_mask_rw_control_reg[7:6] == 2'b11 |=> !match_a)
        else $error("page-only compare matched without page");

    a_dir_a_qual: assert property (breakpoint_mask_rw_control_reg[3] &&
        cpu_read != breakpoint_mask_rw_control_reg[2] |=> !match_a)
        else $error("comparator A direction not honoured");

    a_dir_b_dual: assert property (!full_mode && breakpoint_mask_rw_control_reg[1] &&
        cpu_read != breakpoint_mask_rw_control_reg[0] |=> !match_b)
        else $error("comparator B direction not honoured");

    a_full_data_low: assert property (full_mode && !breakpoint_mask_rw_control_reg[4] &&
        cpu_data[7:0] != comp_b_low_byte_reg |=> !match_b)
        else $error("data low byte not compared");

    a_full_no_dir: assert property (compat_breakpoint_mode && full_mode && cpu_valid &&
        breakpoint_mask_rw_control_reg[5:4] == 2'b11 |=> match_b)
        else $error("full mode data match blocked");

    a_match_needs_cycle: assert property (!cpu_valid |=> !match_a && !match_b)
        else $error("match without bus cycle");

    a_unmapped_error: assert property (setup_phase && !addr_mapped |=> pslverr && pready)
        else $error("unmapped access not flagged");

    c_match_a_seen: cover property (compat_breakpoint_mode ##1 match_a);
    c_full_data_match: cover property (full_mode && trace_debug_mode ##1 match_b);
    c_page_compare: cover property (cpu_page_sel && cpu_valid ##1 match_a);
    c_status_read: cover property (setup_phase && !pwrite && reg_index == bpcm_pkg::IDX_STATUS);
endmodule // bpcm_top

// *** sim/bpcm_cpu_model.sv ***
`timescale 1ns/1ns
module bpcm_cpu_model (
    // clock
    input wire logic pclk,
    // observed cpu bus
    output logic [15:0] cpu_addr,
    output logic [15:0] cpu_data,
    output logic [5:0] cpu_page,
    output logic cpu_page_sel,
    output logic cpu_read,
    output logic cpu_valid
);
    initial
    begin
        cpu_addr = 16'h0000;
        cpu_data = 16'h0000;
        cpu_page = 6'h00;
        cpu_page_sel = 1'b0;
        cpu_read = 1'b0;
        cpu_valid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain cycles only
    task automatic drive(logic [15:0] a, logic [15:0] d, logic [5:0] p, logic ps, logic rd);
        @(posedge pclk);
        cpu_addr <= a;
        cpu_data <= d;
        cpu_page <= p;
        cpu_page_sel <= ps;
        cpu_read <= rd;
        cpu_valid <= 1'b1;
    endtask

    // released lines show the inverse of their last value
    task automatic idle();
        @(posedge pclk);
        cpu_valid <= 1'b0;
        cpu_addr <= ~cpu_addr;
        cpu_data <= ~cpu_data;
        cpu_page <= ~cpu_page;
        cpu_page_sel <= ~cpu_page_sel;
        cpu_read <= ~cpu_read;
    endtask
endmodule // bpcm_cpu_model

// *** sim/bpcm_top_tb.sv ***
`timescale 1ns/1ns
module bpcm_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [15:0] cpu_addr;
    logic [15:0] cpu_data;
    logic [5:0] cpu_page;
    logic cpu_page_sel;
    logic cpu_read;
    logic cpu_valid;
    logic match_a;
    logic match_b;
    int err_total = 0;
    int samples_checked = 0;
    logic [1:0] exp_q[$];
    logic v_d = 1'b0;
    // ctrl, a ext, a high, a low, b ext, b high, b low
    logic [7:0] cfg [7];
    logic [7:0] mode = 8'h00;

    always #2 pclk = ~pclk;

    bpcm_cpu_model u_cpu (.pclk(pclk), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_page(cpu_page),
        .cpu_page_sel(cpu_page_sel), .cpu_read(cpu_read), .cpu_valid(cpu_valid));

    bpcm_top #(.ADDR_W(12)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_page(cpu_page),
        .cpu_page_sel(cpu_page_sel), .cpu_read(cpu_read), .cpu_valid(cpu_valid),
        .match_a(match_a), .match_b(match_b));

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(logic wr, logic [7:0] idx, logic [7:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_total++;
            summarize();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(logic [7:0] idx, logic [7:0] wd, logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, wd, r, e);
        check("write_err", {31'h0, e}, {31'h0, exp_err});
    endtask

    task automatic rdchk(logic [7:0] idx, logic [7:0] exp, logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        check("read_err", {31'h0, e}, {31'h0, exp_err});
        check("read_data", r, {24'h00_0000, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // masked address compare
    function automatic logic addr_ok(logic [5:0] x, logic [7:0] h, logic [7:0] l, logic [1:0] m,
        logic [15:0] a, logic [5:0] p, logic ps);
        if (!m[0])
            return ps ? (x == p && h[5:0] == a[13:8] && l == a[7:0]) : ({h, l} == a);
        if (m[1])
            return ps && x == p;
        return ps ? (x == p && h[5:0] == a[13:8]) : (h == a[15:8]);
    endfunction

    function automatic logic [1:0] expect_match(logic [15:0] a, logic [15:0] d, logic [5:0] p, logic ps,
        logic rd);
        logic on;
        logic tr;
        logic ea;
        logic eb;
        logic [1:0] ma;
        logic [1:0] mb;
        on = mode[1] | mode[2];
        tr = mode[2] & ~mode[1];
        ma = tr ? 2'b00 : cfg[0][7:6];
        mb = (tr && !mode[0]) ? 2'b00 : cfg[0][5:4];
        ea = on && addr_ok(cfg[1][5:0], cfg[2], cfg[3], ma, a, p, ps) && (!cfg[0][3] || rd == cfg[0][2]);
        if (mode[0])
            eb = on && (mb[1] || cfg[5] == d[15:8]) && (mb[0] || cfg[6] == d[7:0]);
        else
            eb = on && addr_ok(cfg[4][5:0], cfg[5], cfg[6], mb, a, p, ps) && (!cfg[0][1] || rd == cfg[0][0]);
        return {eb, ea};
    endfunction

    task automatic cpu_burst();
        logic [15:0] a;
        logic [15:0] d;
        logic [5:0] p;
        logic ps;
        logic rd;
        repeat (8)
        begin
            a = $urandom_range(1) ? {cfg[2], cfg[3]} : {cfg[5], cfg[6]};
            if ($urandom_range(3) == 0)
                a = a ^ (16'h0001 << $urandom_range(15));
            d = {cfg[5], cfg[6]};
            if ($urandom_range(2) == 0)
                d = d ^ (16'h0001 << $urandom_range(15));
            p = ($urandom_range(2) == 0) ? 6'($urandom) : ($urandom_range(1) ? cfg[1][5:0] : cfg[4][5:0]);
            ps = 1'($urandom);
            rd = 1'($urandom);
            exp_q.push_back(expect_match(a, d, p, ps, rd));
            u_cpu.drive(a, d, p, ps, rd);
            if ($urandom_range(3) == 0)
                u_cpu.idle();
        end
        u_cpu.idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) v_d <= cpu_valid;

    always @(negedge pclk)
    begin
        if (v_d === 1'b1 && exp_q.size() == 0)
            check("match_queue", 32'h1, 32'h0);
        else if (v_d === 1'b1)
            check("match", {30'h0, match_b, match_a}, {30'h0, exp_q.pop_front()});
        else if (presetn === 1'b1)
            check("idle_match", {30'h0, match_b, match_a}, 32'h0);
    end

    initial
    begin
        void'($urandom(28));
        for (int i = 0; i < 7; i++)
            cfg[i] = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdchk(bpcm_pkg::IDX_CTRL + 8'(i), 8'h00, 1'b0);
        wr(8'h28, 8'hFF, 1'b1);
        rdchk(8'h32, 8'h00, 1'b1);
        wr(bpcm_pkg::IDX_STATUS, 8'hFF, 1'b0);
        rdchk(bpcm_pkg::IDX_STATUS, 8'h00, 1'b0);
        repeat (200)
        begin
            mode = 8'($urandom_range(7));
            wr(bpcm_pkg::IDX_MODE, mode, 1'b0);
            for (int i = 0; i < 7; i++)
            begin
                cfg[i] = 8'($urandom);
                wr(bpcm_pkg::IDX_CTRL + 8'(i), cfg[i], 1'b0);
                rdchk(bpcm_pkg::IDX_CTRL + 8'(i), (i == 1 || i == 4) ? {2'b00, cfg[i][5:0]} : cfg[i], 1'b0);
            end
            cpu_burst();
        end
        repeat (4) @(posedge pclk);
        check("queue_left", 32'(exp_q.size()), 32'h0);
        summarize();
    end
endmodule // bpcm_top_tb
